// [inc/lvpmc_consts.vh]
`ifndef LVPMC_CONSTS_VH
`define LVPMC_CONSTS_VH

// Register indices; the APB byte address is four times the index
`define LVPMC_IDX_PSC1 14'h3040
`define LVPMC_IDX_PC2 14'h3041
`define LVPMC_IDX_RSS 14'h3042
`define LVPMC_IDX_MODE 14'h3043

// Reset values
`define LVPMC_PSC1_RST 8'h1c
`define LVPMC_PC2_RST 8'h00
`define LVPMC_RSS_RST 8'h82

// power_status_ctrl_1 fields
`define LVPMC_B_WFLAG 7
`define LVPMC_B_WACK 6
`define LVPMC_B_WIE 5
`define LVPMC_B_RSTEN 4
`define LVPMC_B_INSTOP 3
`define LVPMC_B_DETEN 2
`define LVPMC_B_BGAP 0

// power_ctrl_2 fields
`define LVPMC_B_DLVL 5
`define LVPMC_B_WLVL_HI 4
`define LVPMC_B_WLVL_LO 3

// reset_source_status fields
`define LVPMC_B_SRC_POR 7
`define LVPMC_B_SRC_LVD 1

// Synchroniser width and analog input vector layout
`define LVPMC_SYNC_W 4
`define LVPMC_A_POR 0
`define LVPMC_A_BELOW_LOW 1
`define LVPMC_A_LVD 2
`define LVPMC_A_LVW 3

`endif

// [verilog/lvpmc_sync.v]
`timescale 1ns/1ps
// Two-flop synchroniser for slow analog comparator levels
module lvpmc_sync #(
    parameter WIDTH = 1
) (
    input wire pclk, // Bus clock
    input wire presetn, // Async reset, active low
    input wire [WIDTH-1:0] din, // Asynchronous levels
    output reg [WIDTH-1:0] dout // Levels in the pclk domain
);

reg [WIDTH-1:0] meta;

// First stage feeds only the second stage
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        meta <= {WIDTH{1'b0}};
        dout <= {WIDTH{1'b0}};
    end
    else
    begin
        meta <= din;
        dout <= meta;
    end
end

endmodule

// [verilog/lvpmc_top.v]
`timescale 1ns/1ps
`include "lvpmc_consts.vh"
module lvpmc_top (
    input wire pclk, // Bus clock, 250 MHz
    input wire presetn, // Async reset, active low
    input wire [15:0] paddr, // APB byte address
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB direction, 1 = write
    input wire [31:0] pwdata, // APB write data
    input wire [3:0] pstrb, // APB byte strobes
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error, unmapped address
    input wire wait_exec, // Pulse: wait instruction executed
    input wire stop_exec, // Pulse: stop instruction executed
    input wire stop_enable, // Stop instruction permitted
    input wire debug_mode_enable, // Active debug enabled
    input wire irq_request, // Any enabled interrupt pending
    input wire [5:0] stop_wake_src, // Deep stop wakeup interrupts
    input wire por_active, // Analog power-on detector
    input wire below_low, // Supply under low detect level
    input wire lvd_low, // Supply under selected detect level
    input wire lvw_low, // Supply under selected warn level
    output reg chip_reset, // System reset request, active high
    output reg warn_irq, // Low-voltage warning interrupt
    output reg cpu_clk_enable, // Processor clock enable
    output reg irq_mask_clear, // Pulse: clear interrupt mask
    output reg regulator_full, // Regulator in full regulation
    output reg cpu_standby, // Processor in standby
    output reg ram_standby, // RAM in standby
    output reg periph_standby, // Flash/serial/timer/wdog/debug off
    output reg optional_on, // Optional blocks may stay on
    output reg pin_hold, // Pin states held
    output reg lowv_detect_on, // Detector analog enable
    output reg detect_level_select, // Detect trip level select
    output reg [1:0] warn_level_select, // Warn trip level select
    output reg bandgap_enable // Bandgap reference enable
);

// One-hot reset hold states
localparam RS_RUN = 3'b001;
localparam RS_HPOR = 3'b010;
localparam RS_HLVD = 3'b100;
// One-hot power mode states
localparam MD_RUN = 3'b001;
localparam MD_WAIT = 3'b010;
localparam MD_STOP = 3'b100;

reg [2:0] rst_state;
reg [2:0] next_rst_state;
reg [2:0] mode;
reg [2:0] next_mode;
reg [7:0] psc1;
reg [7:0] pc2;
reg [7:0] rss;
reg rsten_locked;
wire [`LVPMC_SYNC_W-1:0] ana_s;
wire por_s;
wire below_low_s;
wire lvd_s;
wire lvw_s;
wire holding;
wire in_stop;
reg det_active;
wire wr_en;
wire rd_setup;
wire [13:0] widx;
wire hit_psc1;
wire hit_pc2;
wire ack_wr;
wire flag_set;
wire flag_clr;
wire any_wake;
reg [7:0] rd_val;
reg rd_ok;

// Sync into pclk; power-on and below-low lines inverted so cleared flops mean bad
lvpmc_sync #(
    .WIDTH(`LVPMC_SYNC_W)
) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({lvw_low, lvd_low, ~below_low, ~por_active}),
    .dout(ana_s)
);

assign por_s = ~ana_s[`LVPMC_A_POR];
assign below_low_s = ~ana_s[`LVPMC_A_BELOW_LOW];
assign lvd_s = ana_s[`LVPMC_A_LVD];
assign lvw_s = ana_s[`LVPMC_A_LVW];
assign holding = ~rst_state[0];
assign in_stop = mode[2];

// Detector runs while enabled, and in stop only if kept alive.
// During a low-voltage hold it must keep watching the supply.
always @*
begin
    det_active = psc1[`LVPMC_B_DETEN] & (~in_stop |
        psc1[`LVPMC_B_INSTOP] | debug_mode_enable);
    if (rst_state == RS_HLVD)
        det_active = 1'b1;
end

// Reset hold sequencer
always @*
begin
    case (rst_state)
        RS_HPOR:
        begin
            // Release only once above the low detect level
            if (!por_s && !below_low_s)
                next_rst_state = RS_RUN;
            else
                next_rst_state = RS_HPOR;
        end
        RS_HLVD:
        begin
            if (por_s)
                next_rst_state = RS_HPOR;
            else if (!lvd_s)
                next_rst_state = RS_RUN;
            else
                next_rst_state = RS_HLVD;
        end
        RS_RUN:
        begin
            if (por_s)
                next_rst_state = RS_HPOR;
            else if (lvd_s && det_active && psc1[`LVPMC_B_RSTEN])
                next_rst_state = RS_HLVD;
            else
                next_rst_state = RS_RUN;
        end
        default:
            next_rst_state = RS_HPOR;
    endcase
end

// Hold state and reset source flags; flags survive the hold itself
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rst_state <= RS_HPOR;
        rss <= `LVPMC_RSS_RST;
        chip_reset <= 1'b1;
    end
    else
    begin
        rst_state <= next_rst_state;
        chip_reset <= ~next_rst_state[0];
        if (next_rst_state == RS_HPOR && rst_state != RS_HPOR)
        begin
            rss <= 8'h00;
            rss[`LVPMC_B_SRC_POR] <= 1'b1;
            rss[`LVPMC_B_SRC_LVD] <= 1'b1;
        end
        else if (next_rst_state == RS_HLVD && rst_state != RS_HLVD)
        begin
            rss <= 8'h00;
            rss[`LVPMC_B_SRC_LVD] <= 1'b1;
        end
    end
end

// Wakeup from deep stop: pins, serial, converter, comparator, rtc,
// plus the warning interrupt produced here
assign any_wake = (|stop_wake_src) | warn_irq;

// Power mode sequencer; a hold always forces run
always @*
begin
    case (mode)
        MD_RUN:
        begin
            if (stop_exec && stop_enable)
                next_mode = MD_STOP;
            else if (wait_exec)
                next_mode = MD_WAIT;
            else
                next_mode = MD_RUN;
        end
        MD_WAIT:
        begin
            if (irq_request | warn_irq)
                next_mode = MD_RUN;
            else
                next_mode = MD_WAIT;
        end
        MD_STOP:
        begin
            if (any_wake)
                next_mode = MD_RUN;
            else
                next_mode = MD_STOP;
        end
        default:
            next_mode = MD_RUN;
    endcase
    if (holding || !next_rst_state[0])
        next_mode = MD_RUN;
end

// Mode state and the power state outputs it drives
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        mode <= MD_RUN;
        cpu_clk_enable <= 1'b1;
        irq_mask_clear <= 1'b0;
        regulator_full <= 1'b1;
        cpu_standby <= 1'b0;
        ram_standby <= 1'b0;
        periph_standby <= 1'b0;
        optional_on <= 1'b1;
        pin_hold <= 1'b0;
    end
    else
    begin
        mode <= next_mode;
        cpu_clk_enable <= next_mode[0];
        irq_mask_clear <= mode[0] & ~next_mode[0];
        // Full regulation except in stop, unless detector or debug
        // must keep running there
        regulator_full <= ~next_mode[2] | debug_mode_enable |
            (psc1[`LVPMC_B_DETEN] & psc1[`LVPMC_B_INSTOP]);
        cpu_standby <= ~next_mode[0];
        ram_standby <= ~next_mode[0];
        periph_standby <= next_mode[2];
        // In stop the optional blocks are forced off regardless of their own enables
        optional_on <= ~next_mode[2];
        pin_hold <= next_mode[2];
    end
end

// APB decode; the word index is the byte address over four
assign widx = paddr[15:2];
assign hit_psc1 = (widx == `LVPMC_IDX_PSC1);
assign hit_pc2 = (widx == `LVPMC_IDX_PC2);
assign wr_en = psel & penable & pready & pwrite & pstrb[0];
assign rd_setup = psel & ~penable;
assign ack_wr = wr_en & hit_psc1 & pwdata[`LVPMC_B_WACK];

// Warning flag: set wins over acknowledge in the same cycle
assign flag_set = lvw_s & det_active;
assign flag_clr = ack_wr & ~lvw_s;

// Control registers; a hold returns them to reset values
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        psc1 <= `LVPMC_PSC1_RST;
        pc2 <= `LVPMC_PC2_RST;
        rsten_locked <= 1'b0;
    end
    else if (holding)
    begin
        psc1 <= `LVPMC_PSC1_RST;
        pc2 <= `LVPMC_PC2_RST;
        rsten_locked <= 1'b0;
    end
    else
    begin
        if (flag_set)
            psc1[`LVPMC_B_WFLAG] <= 1'b1;
        else if (flag_clr)
            psc1[`LVPMC_B_WFLAG] <= 1'b0;
        if (wr_en && hit_psc1)
        begin
            psc1[`LVPMC_B_WIE] <= pwdata[`LVPMC_B_WIE];
            psc1[`LVPMC_B_INSTOP] <= pwdata[`LVPMC_B_INSTOP];
            psc1[`LVPMC_B_DETEN] <= pwdata[`LVPMC_B_DETEN];
            psc1[`LVPMC_B_BGAP] <= pwdata[`LVPMC_B_BGAP];
            // Write-once: only the first write after reset lands
            if (!rsten_locked)
                psc1[`LVPMC_B_RSTEN] <= pwdata[`LVPMC_B_RSTEN];
            rsten_locked <= 1'b1;
        end
        if (wr_en && hit_pc2)
        begin
            pc2[`LVPMC_B_DLVL] <= pwdata[`LVPMC_B_DLVL];
            pc2[`LVPMC_B_WLVL_HI] <= pwdata[`LVPMC_B_WLVL_HI];
            pc2[`LVPMC_B_WLVL_LO] <= pwdata[`LVPMC_B_WLVL_LO];
        end
    end
end

// Read mux; acknowledge and reserved bits read as zero
always @*
begin
    rd_val = 8'h00;
    rd_ok = 1'b1;
    case (widx)
        `LVPMC_IDX_PSC1:
        begin
            rd_val = psc1;
            rd_val[`LVPMC_B_WACK] = 1'b0;
        end
        `LVPMC_IDX_PC2:
            rd_val = pc2;
        `LVPMC_IDX_RSS:
            rd_val = rss;
        `LVPMC_IDX_MODE:
            rd_val = {3'b000, det_active, holding, mode};
        default:
            rd_ok = 1'b0;
    endcase
end

// Ready one cycle after setup; data and error captured with it
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end
    else
    begin
        pready <= rd_setup;
        pslverr <= rd_setup & ~rd_ok;
        if (rd_setup && !pwrite && rd_ok)
            prdata <= {24'h00_0000, rd_val};
        else
            prdata <= 32'h0000_0000;
    end
end

// Analog controls and the warning interrupt
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        warn_irq <= 1'b0;
        lowv_detect_on <= 1'b1;
        detect_level_select <= 1'b0;
        warn_level_select <= 2'b00;
        bandgap_enable <= 1'b0;
    end
    else
    begin
        warn_irq <= psc1[`LVPMC_B_WFLAG] & psc1[`LVPMC_B_WIE] &
            ~holding;
        lowv_detect_on <= det_active | holding;
        detect_level_select <= pc2[`LVPMC_B_DLVL];
        warn_level_select <= {pc2[`LVPMC_B_WLVL_HI],
            pc2[`LVPMC_B_WLVL_LO]};
        bandgap_enable <= psc1[`LVPMC_B_BGAP];
    end
end

endmodule

// [test/lvpmc_monitor.sv]
`timescale 1ns/1ps
// Port-level checks of bus timing and power mode outputs
module lvpmc_monitor (
    input wire pclk, // Bus clock
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pready, // APB ready
    input wire pslverr, // APB error
    input wire wait_exec, // Wait pulse
    input wire stop_exec, // Stop pulse
    input wire stop_enable, // Stop permitted
    input wire chip_reset, // Reset hold
    input wire cpu_clk_enable, // Core clock enable
    input wire irq_mask_clear, // Mask clear pulse
    input wire regulator_full, // Full regulation
    input wire cpu_standby, // Core standby
    input wire ram_standby, // RAM standby
    input wire periph_standby, // Peripherals off
    input wire optional_on, // Optional blocks on
    input wire pin_hold // Pins held
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Requests are taken only in run mode outside a reset hold
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_run;
        cpu_clk_enable && !chip_reset;
    endsequence
    sequence s_stop;
        s_run ##0 stop_exec && stop_enable;
    endsequence
    sequence s_wait;
        s_run ##0 wait_exec && !(stop_exec && stop_enable);
    endsequence
    property p_ready;
        s_setup |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long ready");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_stop;
        s_stop |=> !cpu_clk_enable && periph_standby && cpu_standby;
    endproperty
    a_stop: assert property (p_stop) else $error("stop missed");
    property p_wait;
        s_wait |=> !cpu_clk_enable && ram_standby && !periph_standby;
    endproperty
    a_wait: assert property (p_wait) else $error("wait missed");
    property p_mask;
        $fell(cpu_clk_enable) |-> irq_mask_clear ##1 !irq_mask_clear;
    endproperty
    a_mask: assert property (p_mask) else $error("mask pulse");
    property p_full;
        !periph_standby |-> regulator_full;
    endproperty
    a_full: assert property (p_full) else $error("regulator");
    property p_held;
        pin_hold |-> periph_standby && !optional_on && !cpu_clk_enable;
    endproperty
    a_held: assert property (p_held) else $error("pin hold");
    property p_hold;
        chip_reset |-> cpu_clk_enable && !cpu_standby;
    endproperty
    a_hold: assert property (p_hold) else $error("hold mode");
endmodule

bind lvpmc_top lvpmc_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .wait_exec(wait_exec), .stop_exec(stop_exec),
    .stop_enable(stop_enable), .chip_reset(chip_reset),
    .cpu_clk_enable(cpu_clk_enable), .irq_mask_clear(irq_mask_clear),
    .regulator_full(regulator_full), .cpu_standby(cpu_standby),
    .ram_standby(ram_standby), .periph_standby(periph_standby),
    .optional_on(optional_on), .pin_hold(pin_hold));

// [test/lvpmc_top_tb.sv]
`timescale 1ns/1ps
`include "lvpmc_consts.vh"
module lvpmc_top_tb;
    localparam logic [15:0] A1 = {`LVPMC_IDX_PSC1, 2'b00};
    localparam logic [15:0] A2 = {`LVPMC_IDX_PC2, 2'b00};
    localparam logic [15:0] A3 = {`LVPMC_IDX_RSS, 2'b00};
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'h1;
    logic wait_exec = '0, stop_exec = '0, stop_enable = '1, dbg = '0;
    logic irq_request = '0, por_active = '1, below_low = '1;
    logic lvd_low = '0, lvw_low = '0;
    logic [5:0] wake = '0;
    wire [31:0] prdata;
    wire pready, pslverr, chip_reset, warn_irq, cpu_clk_enable, mclr;
    wire regulator_full, cpu_standby, ram_standby, periph_standby, opt_on;
    wire pin_hold, det_on, dlvl, bgap;
    wire [1:0] wlvl;
    logic [33:0] exp_q [$];
    logic [33:0] e;
    logic [7:0] r;
    int err_count = 0, cmp_count = 0, i;

    lvpmc_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wait_exec(wait_exec), .stop_exec(stop_exec),
        .stop_enable(stop_enable), .debug_mode_enable(dbg),
        .irq_request(irq_request), .stop_wake_src(wake),
        .por_active(por_active), .below_low(below_low), .lvd_low(lvd_low),
        .lvw_low(lvw_low), .chip_reset(chip_reset), .warn_irq(warn_irq),
        .cpu_clk_enable(cpu_clk_enable), .irq_mask_clear(mclr),
        .regulator_full(regulator_full), .cpu_standby(cpu_standby),
        .ram_standby(ram_standby), .periph_standby(periph_standby),
        .optional_on(opt_on), .pin_hold(pin_hold), .lowv_detect_on(det_on),
        .detect_level_select(dlvl), .warn_level_select(wlvl),
        .bandgap_enable(bgap));

    always #2 pclk = ~pclk;

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the answer is noted for the watcher
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [7:0] d, input logic [7:0] x, input logic er);
        int n;
        exp_q.push_back({!w && !er, er, 24'h0, x});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            err_count++;
            end_sim;
        end
    endtask

    // Bounded wait for the reset hold output to settle
    task automatic wait_rst(input logic v);
        int n;
        n = 0;
        while (chip_reset !== v && n < 40)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk({31'h0, chip_reset}, {31'h0, v});
        if (n >= 40)
            end_sim;
    endtask

    // Answers are compared in order as each ready appears
    always @(posedge pclk)
    begin
        if (pready === 1'b1)
        begin
            e = exp_q.pop_front();
            chk({31'h0, pslverr}, {31'h0, e[32]});
            if (e[33])
                chk(prdata, e[31:0]);
        end
    end

    // Main sequence; analog levels need sync cycles before they act
    initial
    begin
        i = $urandom(32'hce2cb3e1);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, A1, 8'h00, 8'h00, 1'b0);
        apb(1'b0, A1, 8'h00, 8'h1c, 1'b0);
        por_active <= 1'b0;
        repeat (6) @(posedge pclk);
        #1;
        chk({31'h0, chip_reset}, 32'h1);
        @(posedge pclk);
        below_low <= 1'b0;
        wait_rst(1'b0);
        apb(1'b0, A1, 8'h00, 8'h1c, 1'b0);
        apb(1'b0, A2, 8'h00, 8'h00, 1'b0);
        apb(1'b0, A3, 8'h00, 8'h82, 1'b0);
        apb(1'b0, 16'hc110, 8'h00, 8'h00, 1'b1);
        $display("test power-on done");
        lvd_low <= 1'b1;
        wait_rst(1'b1);
        chk({31'h0, det_on}, 32'h1);
        apb(1'b0, A3, 8'h00, 8'h02, 1'b0);
        @(posedge pclk);
        lvd_low <= 1'b0;
        wait_rst(1'b0);
        $display("test low-voltage reset done");
        apb(1'b1, A1, 8'h0d, 8'h00, 1'b0);
        apb(1'b1, A1, 8'h1d, 8'h00, 1'b0);
        apb(1'b0, A1, 8'h00, 8'h0d, 1'b0);
        chk({31'h0, bgap}, 32'h1);
        lvd_low <= 1'b1;
        repeat (6) @(posedge pclk);
        #1;
        chk({31'h0, chip_reset}, 32'h0);
        @(posedge pclk);
        lvd_low <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            r = {2'b00, 1'($urandom()), 2'(i), 3'b000};
            apb(1'b1, A2, r, 8'h00, 1'b0);
            apb(1'b0, A2, 8'h00, r, 1'b0);
            chk({29'h0, dlvl, wlvl}, {29'h0, r[5:3]});
        end
        // A write without its low byte strobe must leave the register
        pstrb <= 4'h0;
        apb(1'b1, A2, 8'h20, 8'h00, 1'b0);
        pstrb <= 4'h1;
        apb(1'b0, A2, 8'h00, r, 1'b0);
        apb(1'b0, {`LVPMC_IDX_MODE, 2'b00}, 8'h00, 8'h11, 1'b0);
        $display("test registers done");
        apb(1'b1, A1, 8'h2d, 8'h00, 1'b0);
        lvw_low <= 1'b1;
        repeat (6) @(posedge pclk);
        #1;
        chk({31'h0, warn_irq}, 32'h1);
        apb(1'b1, A1, 8'h6d, 8'h00, 1'b0);
        apb(1'b0, A1, 8'h00, 8'had, 1'b0);
        lvw_low <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, A1, 8'h6d, 8'h00, 1'b0);
        apb(1'b0, A1, 8'h00, 8'h2d, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        chk({31'h0, warn_irq}, 32'h0);
        $display("test warning done");
        // Stop with detector in stop, without it, and with debug
        for (i = 0; i < 3; i++)
        begin
            apb(1'b1, A1, (i == 0) ? 8'h0d : 8'h05, 8'h00, 1'b0);
            dbg <= (i == 2);
            @(posedge pclk);
            stop_exec <= 1'b1;
            @(posedge pclk);
            stop_exec <= 1'b0;
            #1;
            chk({28'h0, mclr, cpu_clk_enable, pin_hold, periph_standby},
                32'hb);
            chk({31'h0, regulator_full}, {31'h0, i != 1});
            @(posedge pclk);
            wake <= 6'(1 << ($urandom() % 6));
            #1;
            // Detector enable follows the stop state one edge later
            chk({31'h0, det_on}, {31'h0, i != 1});
            @(posedge pclk);
            wake <= '0;
            #1;
            chk({30'h0, cpu_clk_enable, pin_hold}, 32'h2);
        end
        $display("test stop done");
        @(posedge pclk);
        wait_exec <= 1'b1;
        @(posedge pclk);
        wait_exec <= 1'b0;
        #1;
        chk({27'h0, mclr, cpu_clk_enable, ram_standby, periph_standby,
            regulator_full}, 32'h15);
        @(posedge pclk);
        irq_request <= 1'b1;
        @(posedge pclk);
        irq_request <= 1'b0;
        #1;
        chk({31'h0, cpu_clk_enable}, 32'h1);
        $display("test wait done");
        end_sim;
    end
endmodule
